//--- rtl/dtcp_cfg_if.sv
interface dtcp_cfg_if;
	import dtcp_pkg::*;

	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] compare;
	logic [7:0]       dead;
	logic             run;
	logic             start;
	logic [1:0]       mode;
	logic [2:0]       cmp_sel;
	logic [1:0]       clk_sel;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] capture;
	logic             cmp_true;
	logic             ev_tc;
	logic             ev_cmp;
	logic             ev_cap;

	modport regs (
		output period, compare, dead, run, start, mode, cmp_sel, clk_sel,
		input  count, capture, cmp_true, ev_tc, ev_cmp, ev_cap
	);
	modport core (
		input  period, compare, dead, run, start, mode, cmp_sel, clk_sel,
		output count, capture, cmp_true, ev_tc, ev_cmp, ev_cap
	);

endinterface

//--- rtl/dtcp_core.sv
module dtcp_core (
	input  wire logic                    clock,
	input  wire logic                    nrst,
	input  wire logic [3:0]              clk_src,
	input  wire logic                    enable_in,
	input  wire logic                    reset_in,
	input  wire logic                    capture_in,
	input  wire logic                    kill_in,
	output logic                         pwm_out,
	output logic                         pwm_out_n,
	output logic                         tc_out,
	dtcp_cfg_if.core                     cfg
);
	import dtcp_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] capture;
		logic             running;
		logic [3:0]       src_q;
		logic             cap_q;
		logic             rst_q;
		logic             cmp_q;
		logic             tc;
		logic             ev_cap;
		logic             ev_cmp;
		logic             pwm_ref;
		dtcp_db_t         db;
		logic [7:0]       db_cnt;
		logic             out_p;
		logic             out_n;
	} dtcp_core_st_t;

	dtcp_core_st_t st, next_st;

	function automatic logic cmp_eval(input logic [2:0] sel, input logic [CNT_W-1:0] a,
			input logic [CNT_W-1:0] b);
		unique case (sel)
			CMP_LESS:             cmp_eval = a < b;
			CMP_LESS_OR_EQUAL:    cmp_eval = a <= b;
			CMP_EQUAL:            cmp_eval = a == b;
			CMP_GREATER_OR_EQUAL: cmp_eval = a >= b;
			CMP_GREATER:          cmp_eval = a > b;
			default:              cmp_eval = 1'b0;
		endcase
	endfunction

	logic tick;
	logic cmp_now;
	logic permit;

	always_comb begin
		next_st = st;
		next_st.src_q = clk_src;
		next_st.cap_q = capture_in;
		next_st.rst_q = reset_in;
		next_st.tc = 1'b0;
		next_st.ev_cap = 1'b0;
		next_st.ev_cmp = 1'b0;
		tick = clk_src[cfg.clk_sel] & ~st.src_q[cfg.clk_sel];
		cmp_now = cmp_eval(cfg.cmp_sel, st.count, cfg.compare);
		permit = cfg.run & st.running;
		if (cfg.mode == DTCP_MODE_GATED) begin
			permit = permit & enable_in;
		end
		if (capture_in & ~st.cap_q) begin
			next_st.capture = st.count;
			next_st.ev_cap = 1'b1;
		end
		if (cfg.start | (reset_in & ~st.rst_q) | ~cfg.run) begin
			next_st.count = cfg.period;
			// Armed while stopped, so raising run starts a fresh period
			next_st.running = 1'b1;
		end else if (permit & tick) begin
			if (st.count == '0) begin
				next_st.count = cfg.period;
				next_st.tc = 1'b1;
				if (cfg.mode == DTCP_MODE_ONESHOT) begin
					next_st.running = 1'b0;
				end
			end else begin
				next_st.count = st.count - 16'h0001;
			end
		end
		next_st.cmp_q = cmp_now;
		if (cmp_now & ~st.cmp_q) begin
			next_st.ev_cmp = 1'b1;
		end
		next_st.pwm_ref = cmp_now;
		// Deadband: both outputs low for dead plus two cycles at every edge
		unique case (st.db)
			DB_IDLE: begin
				next_st.out_p = 1'b0;
				next_st.out_n = 1'b0;
				next_st.db_cnt = cfg.dead;
				next_st.db = DB_WAIT;
			end
			DB_WAIT: begin
				next_st.out_p = 1'b0;
				next_st.out_n = 1'b0;
				if (st.db_cnt == 8'h00) begin
					next_st.db = st.pwm_ref ? DB_HIGH : DB_LOW;
				end else begin
					next_st.db_cnt = st.db_cnt - 8'h01;
				end
			end
			DB_HIGH: begin
				next_st.out_p = 1'b1;
				if (!st.pwm_ref) begin
					next_st.db = DB_IDLE;
				end
			end
			DB_LOW: begin
				next_st.out_n = 1'b1;
				if (st.pwm_ref) begin
					next_st.db = DB_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
			// Reset period loaded, so the compare detector sees no false rise
			st.count <= PERIOD_RST;
		end else begin
			st <= next_st;
		end
	end

	assign cfg.count = st.count;
	assign cfg.capture = st.capture;
	assign cfg.cmp_true = st.pwm_ref;
	assign cfg.ev_tc = st.tc;
	assign cfg.ev_cmp = st.ev_cmp;
	assign cfg.ev_cap = st.ev_cap;
	assign pwm_out = st.out_p & ~kill_in;
	assign pwm_out_n = st.out_n & ~kill_in;
	assign tc_out = st.tc;

endmodule

//--- rtl/dtcp_pkg.sv
package dtcp_pkg;

	localparam int CNT_W = 16;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_PERIOD  = 8'h04;
	localparam logic [7:0] OFS_COMPARE = 8'h08;
	localparam logic [7:0] OFS_COUNT   = 8'h0c;
	localparam logic [7:0] OFS_CAPTURE = 8'h10;
	localparam logic [7:0] OFS_DEAD    = 8'h14;
	localparam logic [7:0] OFS_STATUS  = 8'h18;
	localparam logic [7:0] OFS_IRQ_EN  = 8'h1c;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h20;

	// Control field positions
	localparam int CTRL_RUN     = 0;
	localparam int CTRL_MODE_LO = 1;
	localparam int CTRL_CMP_LO  = 3;
	localparam int CTRL_CLK_LO  = 6;
	localparam int CTRL_TC_CMPN = 8;
	localparam int CTRL_START   = 9;
	localparam int CTRL_W       = 10;

	// Status / enable bit positions
	localparam int EV_TC   = 0;
	localparam int EV_CMP  = 1;
	localparam int EV_CAP  = 2;
	localparam int EV_W    = 3;

	// Reset values
	localparam logic [15:0] PERIOD_RST  = 16'hffff;
	localparam logic [15:0] COMPARE_RST = 16'h8000;
	localparam logic [7:0]  DEAD_RST    = 8'h00;
	localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;

	typedef enum logic [1:0] {
		DTCP_MODE_FREE    = 2'h0,
		DTCP_MODE_ONESHOT = 2'h1,
		DTCP_MODE_GATED   = 2'h2
	} dtcp_mode_t;

	typedef enum logic [2:0] {
		CMP_LESS             = 3'h0,
		CMP_LESS_OR_EQUAL    = 3'h1,
		CMP_EQUAL            = 3'h2,
		CMP_GREATER_OR_EQUAL = 3'h3,
		CMP_GREATER          = 3'h4
	} dtcp_cmp_t;

	typedef enum logic [1:0] {
		DB_IDLE = 2'h0,
		DB_HIGH = 2'h1,
		DB_WAIT = 2'h3,
		DB_LOW  = 2'h2
	} dtcp_db_t;

endpackage

//--- rtl/dtcp_top.sv
// Overview of operation
// - 16-bit counter counts down only
// - Comparator selectable less/equal/greater variants
// - Period reloads on start, reset, terminal count
// - Interrupt on terminal count, compare, capture
// - One-shot stops at end of period
// - Gated mode counts only while enabled
// - Free-run mode reloads and keeps counting
// - Capture stores all sixteen count bits
// - Reset and capture inputs from routing
// - Kill input forces PWM outputs off
// - Complementary PWM pair with deadband
// - Compare, terminal count, one interrupt output
// - Counting clock chosen among several sources
module dtcp_top (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [3:0]  clk_src,
	input  wire logic        enable_in,
	input  wire logic        reset_in,
	input  wire logic        capture_in,
	input  wire logic        kill_in,
	output logic             cmp_out,
	output logic             tc_out,
	output logic             pwm_out,
	output logic             pwm_out_n,
	output logic             irq,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	import dtcp_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] period;
		logic [CNT_W-1:0] compare;
		logic [7:0]       dead;
		logic [CTRL_W-1:0] ctrl;
		logic [EV_W-1:0]  status;
		logic [EV_W-1:0]  irq_en;
		logic             aw_got;
		logic             w_got;
		logic [7:0]       awaddr;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
		logic             cmp_q;
		logic             tc_q;
	} dtcp_top_st_t;

	dtcp_top_st_t st, next_st;
	dtcp_cfg_if cfg ();

	function automatic logic known_addr(input logic [7:0] a);
		unique case (a)
			OFS_CTRL, OFS_PERIOD, OFS_COMPARE, OFS_COUNT, OFS_CAPTURE,
			OFS_DEAD, OFS_STATUS, OFS_IRQ_EN, OFS_IRQ_CLR: known_addr = 1'b1;
			default: known_addr = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	dtcp_core u_core (
		.clock      (clock),
		.nrst       (nrst),
		.clk_src    (clk_src),
		.enable_in  (enable_in),
		.reset_in   (reset_in),
		.capture_in (capture_in),
		.kill_in    (kill_in),
		.pwm_out    (pwm_out),
		.pwm_out_n  (pwm_out_n),
		.tc_out     (),
		.cfg        (cfg.core)
	);

	assign cfg.period  = st.period;
	assign cfg.compare = st.compare;
	assign cfg.dead    = st.dead;
	assign cfg.run     = st.ctrl[CTRL_RUN];
	assign cfg.start   = st.ctrl[CTRL_START];
	assign cfg.mode    = st.ctrl[CTRL_MODE_LO +: 2];
	assign cfg.cmp_sel = st.ctrl[CTRL_CMP_LO +: 3];
	assign cfg.clk_sel = st.ctrl[CTRL_CLK_LO +: 2];

	logic [EV_W-1:0] ev;
	logic            do_write;
	logic [31:0]     wr_old;
	logic [31:0]     wr_val;
	logic [31:0]     rd_val;

	always_comb begin
		next_st = st;
		ev = '0;
		ev[EV_TC] = cfg.ev_tc;
		ev[EV_CMP] = cfg.ev_cmp;
		ev[EV_CAP] = cfg.ev_cap;
		next_st.cmp_q = cfg.cmp_true;
		next_st.tc_q = cfg.ev_tc;
		next_st.ctrl[CTRL_START] = 1'b0;
		if (s_axi_awvalid & ~st.aw_got) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid & ~st.w_got) begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		do_write = st.aw_got & st.w_got & ~st.bvalid;
		wr_old = '0;
		unique case (st.awaddr)
			OFS_CTRL:    wr_old[CTRL_W-1:0] = st.ctrl;
			OFS_PERIOD:  wr_old[CNT_W-1:0] = st.period;
			OFS_COMPARE: wr_old[CNT_W-1:0] = st.compare;
			OFS_DEAD:    wr_old[7:0] = st.dead;
			OFS_IRQ_EN:  wr_old[EV_W-1:0] = st.irq_en;
			default:     wr_old = '0;
		endcase
		// Strobes applied to the staged word
		wr_val = merge(wr_old, st.wdata, st.wstrb);
		if (do_write) begin
			next_st.bvalid = 1'b1;
			next_st.bresp = known_addr(st.awaddr) ? 2'b00 : 2'b10;
			unique case (st.awaddr)
				OFS_CTRL:    next_st.ctrl = wr_val[CTRL_W-1:0];
				OFS_PERIOD:  next_st.period = wr_val[CNT_W-1:0];
				OFS_COMPARE: next_st.compare = wr_val[CNT_W-1:0];
				OFS_DEAD:    next_st.dead = wr_val[7:0];
				OFS_IRQ_EN:  next_st.irq_en = wr_val[EV_W-1:0];
				default:     next_st.bresp = next_st.bresp;
			endcase
		end
		// Set beats clear when both land together
		next_st.status = st.status;
		if (do_write && st.awaddr == OFS_IRQ_CLR) begin
			next_st.status = st.status & ~wr_val[EV_W-1:0];
		end
		next_st.status = next_st.status | ev;
		if (st.bvalid & s_axi_bready) begin
			next_st.bvalid = 1'b0;
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
		end
		rd_val = BAD_ADDR_DATA;
		unique case (s_axi_araddr)
			OFS_CTRL:    rd_val[CTRL_W-1:0] = st.ctrl;
			OFS_PERIOD:  rd_val[CNT_W-1:0] = st.period;
			OFS_COMPARE: rd_val[CNT_W-1:0] = st.compare;
			OFS_COUNT:   rd_val[CNT_W-1:0] = cfg.count;
			OFS_CAPTURE: rd_val[CNT_W-1:0] = cfg.capture;
			OFS_DEAD:    rd_val[7:0] = st.dead;
			OFS_STATUS:  rd_val[EV_W-1:0] = st.status;
			OFS_IRQ_EN:  rd_val[EV_W-1:0] = st.irq_en;
			default:     rd_val = BAD_ADDR_DATA;
		endcase
		if (s_axi_arvalid & ~st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = rd_val;
			next_st.rresp = (known_addr(s_axi_araddr) && s_axi_araddr != OFS_IRQ_CLR)
				? 2'b00 : 2'b10;
		end else if (st.rvalid & s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
			st.period <= PERIOD_RST;
			st.compare <= COMPARE_RST;
			st.dead <= DEAD_RST;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_awready = ~st.aw_got;
	assign s_axi_wready  = ~st.w_got;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_arready = ~st.rvalid;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign cmp_out = st.cmp_q;
	// Terminal count pin doubles as inverted compare
	assign tc_out = st.ctrl[CTRL_TC_CMPN] ? ~st.cmp_q : st.tc_q;
	assign irq = |(st.status & st.irq_en);

endmodule

//--- sim/dtcp_route_model.sv
module dtcp_route_model (
	input  wire logic clock,
	output logic [3:0] clk_src,
	output logic       enable_in,
	output logic       reset_in,
	output logic       capture_in,
	output logic       kill_in
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		clk_src = 4'h0;
		enable_in = 1'b0;
		reset_in = 1'b0;
		capture_in = 1'b0;
		kill_in = 1'b0;
	end

	// Strobe high one cycle, then idle so the block sees a clean edge
	task automatic pulse(input int k);
		@(posedge clock);
		if (k < 4) clk_src[k] <= 1'b1;
		else if (k == 4) reset_in <= 1'b1;
		else capture_in <= 1'b1;
		@(posedge clock);
		clk_src <= 4'h0;
		reset_in <= 1'b0;
		capture_in <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	task automatic level(input logic en, input logic kill);
		@(posedge clock);
		enable_in <= en;
		kill_in <= kill;
	endtask
endmodule

//--- sim/dtcp_top_props.sv
module dtcp_top_props (
	input wire logic clock,
	input wire logic nrst,
	input wire logic kill_in,
	input wire logic pwm_out,
	input wire logic pwm_out_n,
	input wire logic irq,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [2:0] w_age;

	default clocking @(posedge clock);
	endclocking
	default disable iff (!nrst);

	// Cycles since the last write beat; irq may only drop soon after one
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) w_age <= 3'h7;
		else if (s_axi_wvalid && s_axi_wready) w_age <= 3'h0;
		else if (w_age != 3'h7) w_age <= w_age + 3'h1;
	end

	property p_kill;
		kill_in |-> !pwm_out && !pwm_out_n;
	endproperty
	a_kill: assert property (p_kill) else $error("pwm on under kill");

	property p_excl;
		!(pwm_out && pwm_out_n);
	endproperty
	a_excl: assert property (p_excl) else $error("both pwm high");

	property p_db_on;
		$rose(pwm_out) |-> !$past(pwm_out_n);
	endproperty
	a_db_on: assert property (p_db_on) else $error("no gap before pwm");

	property p_db_off;
		$rose(pwm_out_n) |-> !$past(pwm_out);
	endproperty
	a_db_off: assert property (p_db_off) else $error("no gap before pwm_n");

	property p_rd;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd: assert property (p_rd) else $error("late read data");

	property p_bv;
		$rose(s_axi_bvalid) |-> $past(s_axi_wvalid, 2) && $past(s_axi_wready, 2)
			|| $past(s_axi_awvalid, 2) && $past(s_axi_awready, 2);
	endproperty
	a_bv: assert property (p_bv) else $error("write response timing");

	property p_awr;
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2];
	endproperty
	a_awr: assert property (p_awr) else $error("address ready too soon");

	property p_irqf;
		$fell(irq) |-> w_age < 3'h4;
	endproperty
	a_irqf: assert property (p_irqf) else $error("irq dropped unprompted");
endmodule

bind dtcp_top dtcp_top_props dtcp_top_props_inst (.*);

//--- sim/test_down_timer_counter_pwm.sv
module test_down_timer_counter_pwm;
	timeunit 1ns;
	timeprecision 1ps;
	import dtcp_pkg::*;

	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	wire  [3:0]  clk_src;
	wire         enable_in, reset_in, capture_in, kill_in;
	wire         cmp_out, tc_out, pwm_out, pwm_out_n, irq;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	logic [31:0] rdat, rrs;
	logic        tc_seen = 1'b0;
	int          n_fail = 0, cmp_count = 0, cyc = 0, run = 0, last = 0;

	dtcp_top dtcp_top_inst (.*);
	dtcp_route_model dtcp_route_model_inst (.*);

	task automatic conclude;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) s_axi_bready <= 1'b0;
		end while (!s_axi_bvalid);
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		rrs = {30'h0, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rdat, e);
	endtask

	task automatic tk(input int n);
		repeat (n) dtcp_route_model_inst.pulse(1);
	endtask

	// Two edges so a register write has reached the level output
	task automatic ci(input logic e);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, {31'h0, e});
	endtask

	initial begin
		forever #12.5 clock = ~clock;
	end

	// Length of the last both-low stretch of the pwm pair
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (tc_out) tc_seen <= 1'b1;
		if (!pwm_out && !pwm_out_n) run <= run + 1;
		else if (run != 0) begin
			last <= run;
			run <= 0;
		end
		if (cyc == 20000) begin
			n_fail++;
			conclude();
		end
	end

	initial begin
		repeat (12) @(posedge clock);
		nrst <= 1'b1;
		rc(OFS_PERIOD, 32'hffff);
		rc(OFS_COMPARE, 32'h8000);
		rc(OFS_DEAD, 32'h0);
		rc(OFS_STATUS, 32'h0);
		rd(8'h24);
		chk(rrs, 32'h2);
		chk(rdat, 32'h0);
		$display("t1 done");
		wr(OFS_PERIOD, 32'h3);
		wr(OFS_IRQ_EN, 32'h1);
		wr(OFS_CTRL, 32'h41);
		rc(OFS_COUNT, 32'h3);
		dtcp_route_model_inst.pulse(0);
		rc(OFS_COUNT, 32'h3);
		tk(3);
		rc(OFS_COUNT, 32'h0);
		ci(1'b0);
		chk({31'h0, tc_seen}, 32'h0);
		tk(1);
		rc(OFS_COUNT, 32'h3);
		chk({31'h0, tc_seen}, 32'h1);
		ci(1'b1);
		wr(OFS_IRQ_EN, 32'h0);
		ci(1'b0);
		wr(OFS_IRQ_EN, 32'h1);
		ci(1'b1);
		wr(OFS_IRQ_CLR, 32'h7);
		ci(1'b0);
		$display("t2 done");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_PERIOD, 32'h2);
		wr(OFS_CTRL, 32'h43);
		tk(3);
		ci(1'b1);
		wr(OFS_IRQ_CLR, 32'h7);
		tk(4);
		ci(1'b0);
		$display("t3 done");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_PERIOD, 32'ha5c3);
		wr(OFS_CTRL, 32'h45);
		tk(1);
		rc(OFS_COUNT, 32'ha5c3);
		dtcp_route_model_inst.level(1'b1, 1'b0);
		tk(1);
		rc(OFS_COUNT, 32'ha5c2);
		dtcp_route_model_inst.pulse(5);
		rc(OFS_CAPTURE, 32'ha5c2);
		rd(OFS_STATUS);
		chk({31'h0, rdat[EV_CAP]}, 32'h1);
		tk(1);
		dtcp_route_model_inst.pulse(4);
		rc(OFS_COUNT, 32'ha5c3);
		$display("t4 done");
		wr(OFS_CTRL, 32'h0);
		wr(OFS_PERIOD, 32'h5);
		wr(OFS_COMPARE, 32'h5);
		wr(OFS_IRQ_CLR, 32'h7);
		rd(OFS_STATUS);
		chk({31'h0, rdat[EV_CMP]}, 32'h0);
		for (int c = 0; c < 5; c++) begin
			wr(OFS_CTRL, 32'h41 | (32'(c) << CTRL_CMP_LO));
			repeat (3) @(posedge clock);
			chk({31'h0, cmp_out}, (c >= 1 && c <= 3) ? 32'h1 : 32'h0);
		end
		rd(OFS_STATUS);
		chk({31'h0, rdat[EV_CMP]}, 32'h1);
		wr(OFS_DEAD, 32'h4);
		wr(OFS_CTRL, 32'h151);
		repeat (20) @(posedge clock);
		// Gap is dead plus two: one edge to leave a drive state, one to enter the next
		chk(32'(last), 32'h6);
		chk({30'h0, pwm_out, pwm_out_n}, 32'h2);
		chk({30'h0, cmp_out, tc_out}, 32'h2);
		dtcp_route_model_inst.level(1'b1, 1'b1);
		repeat (2) @(posedge clock);
		chk({30'h0, pwm_out, pwm_out_n}, 32'h0);
		dtcp_route_model_inst.level(1'b1, 1'b0);
		wr(OFS_CTRL, 32'h161);
		repeat (20) @(posedge clock);
		chk(32'(last), 32'h6);
		chk({30'h0, pwm_out, pwm_out_n}, 32'h1);
		chk({30'h0, cmp_out, tc_out}, 32'h1);
		$display("t5 done");
		conclude();
	end
endmodule
